// ### pkg/exec_pkg.sv
package exec_pkg;

  // Opcode patterns of the instruction group.
  localparam logic [4:0] OP_IMM_MOVE = 5'h04;
  localparam logic [7:0] OP_REG_COPY = 8'h46;
  localparam logic [9:0] OP_FLAG_COPY = 10'h000;
  localparam logic [9:0] OP_MULTIPLY = 10'h10D;
  localparam logic [9:0] OP_INVERSE = 10'h10F;
  localparam logic [9:0] OP_NEGATE = 10'h109;
  localparam logic [15:0] OP_NOP_HINT = 16'hBF00;
  localparam logic [11:0] OP_SPECIAL_READ_HI = 12'hF3E;
  localparam logic [11:0] OP_SPECIAL_WRITE_HI = 12'hF38;

  // Register indices and special register selectors.
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [7:0] SEL_STATUS = 8'h00;
  localparam logic [7:0] SEL_CONTROL = 8'h14;

  // Reset values.
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] SPECIAL_RESET = 8'h00;

  typedef enum logic [3:0] {
    KIND_NONE = 4'h0,
    KIND_IMM_MOVE = 4'h1,
    KIND_REG_COPY = 4'h2,
    KIND_FLAG_COPY = 4'h3,
    KIND_MULTIPLY = 4'h4,
    KIND_INVERSE = 4'h5,
    KIND_NEGATE = 4'h6,
    KIND_NOP_HINT = 4'h7,
    KIND_SPECIAL_READ = 4'h8,
    KIND_SPECIAL_WRITE = 4'h9
  } kind_t;

endpackage

// ### src/instr_classify.sv
`timescale 1ns/1ps
module instr_classify (
  input wire logic [15:0] instr_lo,
  input wire logic [15:0] instr_hi,
  output exec_pkg::kind_t kind,
  output logic wide
);
  always_comb begin
    kind = exec_pkg::KIND_NONE;
    wide = 1'b0;
    if (instr_lo[15:11] == exec_pkg::OP_IMM_MOVE) begin
      kind = exec_pkg::KIND_IMM_MOVE;
    end else if (instr_lo[15:8] == exec_pkg::OP_REG_COPY) begin
      kind = exec_pkg::KIND_REG_COPY;
    end else if (instr_lo[15:6] == exec_pkg::OP_FLAG_COPY) begin
      kind = exec_pkg::KIND_FLAG_COPY;
    end else if (instr_lo[15:6] == exec_pkg::OP_MULTIPLY) begin
      kind = exec_pkg::KIND_MULTIPLY;
    end else if (instr_lo[15:6] == exec_pkg::OP_INVERSE) begin
      kind = exec_pkg::KIND_INVERSE;
    end else if (instr_lo[15:6] == exec_pkg::OP_NEGATE) begin
      kind = exec_pkg::KIND_NEGATE;
    end else if (instr_lo == exec_pkg::OP_NOP_HINT) begin
      kind = exec_pkg::KIND_NOP_HINT;
    end else if (instr_lo[15:4] == exec_pkg::OP_SPECIAL_READ_HI) begin
      kind = exec_pkg::KIND_SPECIAL_READ;
      wide = 1'b1;
    end else if (instr_lo[15:4] == exec_pkg::OP_SPECIAL_WRITE_HI) begin
      kind = exec_pkg::KIND_SPECIAL_WRITE;
      wide = 1'b1;
    end
  end
endmodule // instr_classify

// ### src/low_multiplier.sv
`timescale 1ns/1ps
module low_multiplier (
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  output logic [31:0] product_lo
);
  logic [63:0] full_product;

  // The low word is the same for signed and unsigned operands.
  assign full_product = op_a * op_b;
  assign product_lo = full_product[31:0];
endmodule // low_multiplier

// ### src/move_multiply_not_exec.sv
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - Immediate move zero-extends an 8-bit constant into a low register.
// - Immediate move sets N from bit 31, Z on zero; C, V kept.
// - Register copy writes source unchanged; high bit joins destination field.
// - Flag-setting copy sets N and Z; C and V kept.
// - Copy into register 15 branches and touches no flag.
// - Special read copies the status flags into a general register; other selectors read zero.
// - Special write copies a general register into a special register.
// - Multiply stores the low 32 product bits into the second operand register.
// - One multiplier serves signed and unsigned operands alike.
// - Flag-setting multiply sets N and Z; C and V kept.
// - Inverse writes complement; N, Z from result, C from shifter, V kept.
// - Negate runs as flag-setting reverse subtract from zero.
// - The hint changes no register, flag or memory.
// - The hint has no guaranteed timing.
// - Nothing executes unless its condition passes; nothing raises an exception.
module move_multiply_not_exec (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_lo,
  input wire logic [15:0] instr_hi,
  input wire logic cond_pass,
  input wire logic privileged,
  input wire logic [31:0] rd_data_a,
  input wire logic [31:0] rd_data_b,
  output logic [3:0] rd_addr_a,
  output logic [3:0] rd_addr_b,
  output logic wr_en,
  output logic [3:0] wr_addr,
  output logic [31:0] wr_data,
  output logic branch_taken,
  output logic [31:0] branch_target,
  output logic [3:0] flags,
  output logic special_wr_en,
  output logic [7:0] special_sel,
  output logic [31:0] special_wr_data,
  output logic system_access,
  output logic instr_done,
  output logic wide_instr
);

  // ************************************************************
  // Decode
  // ************************************************************
  exec_pkg::kind_t kind;
  logic wide;
  logic [3:0] dest_idx;
  logic [3:0] src_idx;
  logic [7:0] sel;
  logic fire;
  logic [31:0] result;
  logic [31:0] special_word;
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  logic wr_en_next;
  logic branch_next;
  logic sys_next;
  logic [31:0] result_mul;

  instr_classify u_classify (
    .instr_lo(instr_lo),
    .instr_hi(instr_hi),
    .kind(kind),
    .wide(wide)
  );

  low_multiplier u_multiplier (
    .op_a(rd_data_a),
    .op_b(rd_data_b),
    .product_lo(result_mul)
  );

  function automatic logic [3:0] nz_update(input logic [3:0] old, input logic [31:0] val);
    nz_update = {val[31], (val == 32'h0000_0000), old[1], old[0]};
  endfunction

  assign fire = instr_valid && cond_pass;
  assign sel = instr_hi[7:0];

  always_comb begin
    dest_idx = {1'b0, instr_lo[2:0]};
    src_idx = {1'b0, instr_lo[5:3]};
    unique case (kind)
      exec_pkg::KIND_IMM_MOVE: begin
        dest_idx = {1'b0, instr_lo[10:8]};
      end
      exec_pkg::KIND_REG_COPY: begin
        dest_idx = {instr_lo[7], instr_lo[2:0]};
        src_idx = instr_lo[6:3];
      end
      exec_pkg::KIND_SPECIAL_READ: begin
        dest_idx = instr_hi[11:8];
      end
      exec_pkg::KIND_SPECIAL_WRITE: begin
        src_idx = instr_lo[3:0];
      end
      default: begin
      end
    endcase
  end

  assign rd_addr_a = src_idx;
  assign rd_addr_b = dest_idx;

  // ************************************************************
  // Special register selection
  // ************************************************************
  always_comb begin
    special_word = exec_pkg::WORD_RESET;
    if (sel == exec_pkg::SEL_STATUS) begin
      special_word = {flags_reg, 28'h000_0000};
    end
  end

  // ************************************************************
  // Execute
  // ************************************************************
  always_comb begin
    result = exec_pkg::WORD_RESET;
    flags_next = flags_reg;
    wr_en_next = 1'b0;
    branch_next = 1'b0;
    sys_next = 1'b0;
    if (fire) begin
      unique case (kind)
        exec_pkg::KIND_IMM_MOVE: begin
          result = {24'h00_0000, instr_lo[7:0]};
          flags_next = nz_update(flags_reg, result);
          wr_en_next = 1'b1;
        end
        exec_pkg::KIND_REG_COPY: begin
          result = rd_data_a;
          if (dest_idx == exec_pkg::REG_PC) begin
            branch_next = 1'b1;
          end else begin
            wr_en_next = 1'b1;
          end
        end
        exec_pkg::KIND_FLAG_COPY: begin
          result = rd_data_a;
          flags_next = nz_update(flags_reg, result);
          wr_en_next = 1'b1;
        end
        exec_pkg::KIND_MULTIPLY: begin
          result = result_mul;
          flags_next = nz_update(flags_reg, result);
          wr_en_next = 1'b1;
        end
        exec_pkg::KIND_INVERSE: begin
          result = ~rd_data_a;
          // With no shift the shifter carry is the current carry.
          flags_next = nz_update(flags_reg, result);
          wr_en_next = 1'b1;
        end
        exec_pkg::KIND_NEGATE: begin
          result = 32'h0000_0000 - rd_data_a;
          flags_next = {result[31], (result == 32'h0000_0000),
                        (rd_data_a == 32'h0000_0000),
                        (rd_data_a[31] & result[31])};
          wr_en_next = 1'b1;
        end
        exec_pkg::KIND_SPECIAL_READ: begin
          result = special_word;
          wr_en_next = 1'b1;
          sys_next = !(sel == exec_pkg::SEL_STATUS || sel == exec_pkg::SEL_CONTROL);
        end
        exec_pkg::KIND_SPECIAL_WRITE: begin
          if (sel == exec_pkg::SEL_STATUS) begin
            flags_next = rd_data_a[31:28];
          end else begin
            sys_next = 1'b1;
          end
        end
        exec_pkg::KIND_NOP_HINT: begin
        end
        exec_pkg::KIND_NONE: begin
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // State and outputs
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_reg <= exec_pkg::FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_en <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= exec_pkg::WORD_RESET;
      branch_taken <= 1'b0;
      branch_target <= exec_pkg::WORD_RESET;
      instr_done <= 1'b0;
      wide_instr <= 1'b0;
      system_access <= 1'b0;
    end else begin
      wr_en <= wr_en_next;
      wr_addr <= dest_idx;
      wr_data <= result;
      branch_taken <= branch_next;
      branch_target <= result;
      // The hint retires in one cycle like the rest; no timing promise is made.
      instr_done <= instr_valid;
      wide_instr <= instr_valid && wide;
      system_access <= sys_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      special_wr_en <= 1'b0;
      special_sel <= exec_pkg::SPECIAL_RESET;
      special_wr_data <= exec_pkg::WORD_RESET;
    end else begin
      special_wr_en <= fire && (kind == exec_pkg::KIND_SPECIAL_WRITE);
      special_sel <= sel;
      special_wr_data <= rd_data_a;
    end
  end

  assign flags = flags_reg;

endmodule // move_multiply_not_exec

// ### tb/reg_file_model.sv
`timescale 1ns/1ps
module reg_file_model (
  input wire logic ref_clk,
  input wire logic [3:0] rd_addr_a,
  input wire logic [3:0] rd_addr_b,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b
);
  logic [31:0] regs [16];
  assign rd_data_a = regs[rd_addr_a];
  assign rd_data_b = regs[rd_addr_b];
  always @(posedge ref_clk) begin
    if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end
  end
endmodule // reg_file_model

// ### tb/exec_monitor.sv
`timescale 1ns/1ps
module exec_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_lo,
  input wire logic cond_pass,
  input wire logic [31:0] rd_data_a,
  input wire logic [31:0] rd_data_b,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic branch_taken,
  input wire logic [31:0] branch_target,
  input wire logic [3:0] flags,
  input wire logic instr_done
);
  logic [15:0] lo_d;
  logic [31:0] a_d;
  logic [31:0] b_d;
  logic [3:0] f_d;
  always_ff @(posedge ref_clk) begin
    lo_d <= instr_lo;
    a_d <= rd_data_a;
    b_d <= rd_data_b;
    f_d <= flags;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_go(logic [9:0] op);
    instr_valid && cond_pass && instr_lo[15:6] == op;
  endsequence
  sequence s_copy;
    instr_valid && cond_pass && instr_lo[15:8] == exec_pkg::OP_REG_COPY;
  endsequence
  a_done_pulse: assert property (instr_valid |=> instr_done)
    else $error("instruction not completed");
  a_refused_quiet: assert property (
    instr_valid && !cond_pass |=> !wr_en && !branch_taken && flags == f_d)
    else $error("failed condition changed state");
  a_imm_zero_ext: assert property (
    instr_valid && cond_pass && instr_lo[15:11] == exec_pkg::OP_IMM_MOVE |=> wr_en
    && wr_data == {24'h0, lo_d[7:0]} && flags == {1'b0, lo_d[7:0] == 8'h00, f_d[1:0]})
    else $error("immediate move wrong");
  a_copy_value: assert property (
    s_copy ##0 {instr_lo[7], instr_lo[2:0]} != exec_pkg::REG_PC |=> wr_en
    && wr_data == a_d && wr_addr == {lo_d[7], lo_d[2:0]} && flags == f_d)
    else $error("register copy wrong");
  a_pc_branch: assert property (
    s_copy ##0 {instr_lo[7], instr_lo[2:0]} == exec_pkg::REG_PC |=> branch_taken
    && !wr_en && branch_target == a_d && flags == f_d)
    else $error("copy to counter wrong");
  a_flag_copy: assert property (
    s_go(exec_pkg::OP_FLAG_COPY) |=> wr_data == a_d
    && flags == {a_d[31], a_d == 32'h0000_0000, f_d[1:0]})
    else $error("flag-setting copy wrong");
  a_mul_low: assert property (
    s_go(exec_pkg::OP_MULTIPLY) |=> wr_data == a_d * b_d && wr_addr == {1'b0, lo_d[2:0]}
    && flags == {wr_data[31], wr_data == 32'h0000_0000, f_d[1:0]})
    else $error("multiply wrong");
  a_inverse_flags: assert property (
    s_go(exec_pkg::OP_INVERSE) |=> wr_data == ~a_d
    && flags == {~a_d[31], a_d == 32'hFFFF_FFFF, f_d[1:0]})
    else $error("inverse wrong");
  a_nop_quiet: assert property (
    instr_valid && instr_lo == exec_pkg::OP_NOP_HINT |=> !wr_en && !branch_taken && flags == f_d)
    else $error("hint changed state");
endmodule // exec_monitor
bind move_multiply_not_exec exec_monitor u_mon (.ref_clk(ref_clk), .rst(rst),
  .instr_valid(instr_valid), .instr_lo(instr_lo), .cond_pass(cond_pass),
  .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .wr_en(wr_en), .wr_addr(wr_addr),
  .wr_data(wr_data), .branch_taken(branch_taken), .branch_target(branch_target),
  .flags(flags), .instr_done(instr_done));

// ### tb/move_multiply_not_exec_tb.sv
`timescale 1ns/1ps
module move_multiply_not_exec_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic cond_pass = 1'b0;
  logic [15:0] instr_lo = 16'h0000;
  logic [15:0] instr_hi = 16'h0000;
  logic [3:0] rd_addr_a, rd_addr_b, wr_addr, flags;
  logic [31:0] rd_data_a, rd_data_b, wr_data, branch_target;
  logic wr_en, branch_taken, instr_done;
  logic special_wr_en, system_access, wide_instr;
  logic [7:0] special_sel;
  logic [31:0] special_wr_data;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  always #25 ref_clk = ~ref_clk;
  move_multiply_not_exec u_dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_lo(instr_lo), .instr_hi(instr_hi), .cond_pass(cond_pass), .privileged(1'b0),
    .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .rd_addr_a(rd_addr_a),
    .rd_addr_b(rd_addr_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .branch_taken(branch_taken), .branch_target(branch_target), .flags(flags),
    .special_wr_en(special_wr_en), .special_sel(special_sel),
    .special_wr_data(special_wr_data), .system_access(system_access),
    .instr_done(instr_done), .wide_instr(wide_instr));
  reg_file_model u_rf (.ref_clk(ref_clk), .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_data_a(rd_data_a),
    .rd_data_b(rd_data_b));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected e is {done, branch, write, write index}.
  task automatic ex(input logic [15:0] lo, input logic cp, input logic [6:0] e,
      input logic [31:0] d, input logic [3:0] f);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_lo <= lo;
    cond_pass <= cp;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    chk(32'({instr_done, branch_taken, wr_en}), 32'(e[6:4]));
    if (e[4]) begin
      chk(32'(wr_addr), 32'(e[3:0]));
      chk(wr_data, d);
    end
    if (e[5]) begin
      chk(branch_target, d);
    end
    chk(32'(flags), 32'(f));
  endtask
  // Expected e is {system access, special write, write, wide, done}.
  task automatic sp(input logic [15:0] lo, input logic [15:0] hi, input logic [4:0] e,
      input logic [31:0] d, input logic [3:0] f);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_lo <= lo;
    instr_hi <= hi;
    cond_pass <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    chk(32'({system_access, special_wr_en, wr_en, wide_instr, instr_done}), 32'(e));
    if (e[2]) begin
      chk(32'(wr_addr), 32'(hi[11:8]));
      chk(wr_data, d);
    end
    if (e[3]) begin
      chk(32'(special_sel), 32'(hi[7:0]));
      chk(special_wr_data, d);
    end
    chk(32'(flags), 32'(f));
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    ex(16'h2105, 1'b1, 7'h51, 32'h0000_0005, 4'h0);
    ex(16'h2000, 1'b1, 7'h50, 32'h0000_0000, 4'h4);
    ex(16'h22FF, 1'b1, 7'h52, 32'h0000_00FF, 4'h0);
    ex(16'h43CB, 1'b1, 7'h53, 32'hFFFF_FFFA, 4'h8);
    ex(16'h424C, 1'b1, 7'h54, 32'hFFFF_FFFB, 4'h8);
    ex(16'h4245, 1'b1, 7'h55, 32'h0000_0000, 4'h6);
    ex(16'h4353, 1'b1, 7'h53, 32'hFFFF_FA06, 4'hA);
    ex(16'h002E, 1'b1, 7'h56, 32'h0000_0000, 4'h6);
    ex(16'h4690, 1'b1, 7'h58, 32'h0000_00FF, 4'h6);
    ex(16'h4647, 1'b1, 7'h57, 32'h0000_00FF, 4'h6);
    ex(16'h469F, 1'b1, 7'h60, 32'hFFFF_FA06, 4'h6);
    ex(16'hBF00, 1'b1, 7'h40, 32'h0000_0000, 4'h6);
    ex(16'h2100, 1'b0, 7'h40, 32'h0000_0000, 4'h6);
    ex(16'h2100, 1'b1, 7'h51, 32'h0000_0000, 4'h6);
    sp(16'hF3EF, 16'h8500, 5'h07, 32'h6000_0000, 4'h6);
    sp(16'hF3EF, 16'h8608, 5'h17, 32'h0000_0000, 4'h6);
    sp(16'hF384, 16'h8800, 5'h0B, 32'hFFFF_FFFB, 4'hF);
    sp(16'hF385, 16'h8814, 5'h1B, 32'h6000_0000, 4'hF);
    conclude();
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_mismatch++;
      conclude();
    end
  end
endmodule // move_multiply_not_exec_tb
